// *** verilog/cprm_defines.svh ***
// Purpose: constants of the cyclic process data mapper
// Assumes: 250 MHz clock
// Notes: times in ns, cycle counts derived where used
`ifndef CPRM_DEFINES_SVH
`define CPRM_DEFINES_SVH
`define CPRM_SLOTS 5
`define CPRM_WORD_W 32
`define CPRM_SUB_W 6
`define CPRM_SUB_TX_BASE 6'h10
`define CPRM_SUB_RX_BASE 6'h16
`define CPRM_SUB_LAST 6'h1f
`define CPRM_MODULE_SHIFT 16
`define CPRM_STATUS_REG 32'h00000023
`define CPRM_TX_DEF0 32'h00000002
`define CPRM_TX_DEF1 32'h0000000a
`define CPRM_TX_DEF2 32'h0000000c
`define CPRM_TX_DEF3 32'h000000a9
`define CPRM_TX_DEF4 32'h00000023
`define CPRM_RX_DEF0 32'h00000002
`define CPRM_RX_DEF1 32'h00000003
`define CPRM_RX_DEF2 32'h00000005
`define CPRM_RX_DEF3 32'h00000007
`define CPRM_RX_DEF4 32'h00000000
`define CPRM_TX_DEF_LEN 3'h5
`define CPRM_RX_DEF_LEN 3'h4
`define CPRM_CLK_NS 4
`define CPRM_BASE_NS 360000
`define CPRM_STEP_NS 35000
`define CPRM_STAT_NS 30000
`endif

// *** verilog/cprm_pkg.sv ***
// Purpose: shared types of the cyclic process data mapper
// Assumes: cprm_defines.svh on the include path
// Notes: none
`include "cprm_defines.svh"
package cprm_pkg;
	typedef logic [`CPRM_WORD_W-1:0] cprm_word_t;
	typedef cprm_word_t [`CPRM_SLOTS-1:0] cprm_slots_t;
	typedef logic [2:0] cprm_len_t;
	typedef logic [`CPRM_SUB_W-1:0] cprm_sub_t;
	typedef enum logic [2:0] {
		D_IDLE, D_RX, D_TX_ADDR, D_TX_DATA, D_STAT_ADDR, D_STAT_DATA
	} cprm_dev_state_t;
	typedef enum logic [1:0] {M_IDLE, M_REQ, M_RESP} cprm_mst_state_t;
endpackage

// *** verilog/cprm_link_if.sv ***
// Purpose: link between managing node and drive module
// Assumes: one clock, no clocking block
// Notes: words move with valid only, no back-pressure
`timescale 1ns/1ps
interface cprm_link_if;
	import cprm_pkg::*;
	logic soc;
	logic preq_valid;
	cprm_word_t preq_data;
	logic preq_last;
	logic pres_valid;
	cprm_word_t pres_data;
	logic pres_last;
	logic sdo_valid;
	cprm_sub_t sdo_sub;
	cprm_word_t sdo_data;
	logic sdo_save;
	modport dev (
		input soc, preq_valid, preq_data, preq_last, sdo_valid, sdo_sub, sdo_data, sdo_save,
		output pres_valid, pres_data, pres_last
	);
	modport mst (
		output soc, preq_valid, preq_data, preq_last, sdo_valid, sdo_sub, sdo_data, sdo_save,
		input pres_valid, pres_data, pres_last
	);
endinterface

// *** verilog/cprm_map_table.sv ***
// Purpose: mapping lists, saved copy and active copy
// Assumes: por_n marks power-up, reset_n every restart
// Notes: edits take effect only after save and restart
`timescale 1ns/1ps
`include "cprm_defines.svh"
module cprm_map_table (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic por_n,
	input wire logic cfg_valid,
	input cprm_pkg::cprm_sub_t cfg_sub,
	input cprm_pkg::cprm_word_t cfg_data,
	input wire logic cfg_save,
	output cprm_pkg::cprm_slots_t tx_map,
	output cprm_pkg::cprm_slots_t rx_map,
	output cprm_pkg::cprm_len_t tx_len,
	output cprm_pkg::cprm_len_t rx_len,
	output logic status_mapped
);
	import cprm_pkg::*;

	localparam cprm_slots_t TX_DEF = {`CPRM_TX_DEF4, `CPRM_TX_DEF3, `CPRM_TX_DEF2,
		`CPRM_TX_DEF1, `CPRM_TX_DEF0};
	localparam cprm_slots_t RX_DEF = {`CPRM_RX_DEF4, `CPRM_RX_DEF3, `CPRM_RX_DEF2,
		`CPRM_RX_DEF1, `CPRM_RX_DEF0};

	cprm_slots_t nv_tx_q, nv_rx_q, stg_tx_q, stg_rx_q;
	logic load_q;

	// Length up to first empty slot
	function automatic cprm_len_t list_len(input cprm_slots_t m);
		cprm_len_t n;
		logic stop;
		n = '0;
		stop = 1'b0;
		for (int i = 0; i < `CPRM_SLOTS; i++) begin
			if (m[i] == '0) begin
				stop = 1'b1;
			end
			if (!stop) begin
				n = n + 3'h1;
			end
		end
		return n;
	endfunction

	function automatic logic has_status(input cprm_slots_t m, input cprm_len_t n);
		logic f;
		f = 1'b0;
		for (int i = 0; i < `CPRM_SLOTS; i++) begin
			if (i < int'(n) && m[i] == `CPRM_STATUS_REG) begin
				f = 1'b1;
			end
		end
		return f;
	endfunction

	////////////////////////////////////////////////////////////////
	// Staged edits, one slot per generate entry
	generate
		for (genvar g = 0; g < `CPRM_SLOTS; g++) begin : g_slot
			always_ff @(posedge clk or negedge reset_n) begin
				if (!reset_n) begin
					stg_tx_q[g] <= TX_DEF[g];
					stg_rx_q[g] <= RX_DEF[g];
				end else if (load_q) begin
					stg_tx_q[g] <= nv_tx_q[g];
					stg_rx_q[g] <= nv_rx_q[g];
				end else if (cfg_valid) begin
					if (cfg_sub == `CPRM_SUB_TX_BASE + cprm_sub_t'(g)) begin
						stg_tx_q[g] <= cfg_data;
					end
					if (cfg_sub == `CPRM_SUB_RX_BASE + cprm_sub_t'(g)) begin
						stg_rx_q[g] <= cfg_data;
					end
				end
			end
		end
	endgenerate

	////////////////////////////////////////////////////////////////
	// Non-volatile copy, survives reset_n
	always_ff @(posedge clk or negedge por_n) begin
		if (!por_n) begin
			nv_tx_q <= TX_DEF;
			nv_rx_q <= RX_DEF;
		end else if (cfg_save && !load_q) begin
			nv_tx_q <= stg_tx_q;
			nv_rx_q <= stg_rx_q;
		end
	end

	////////////////////////////////////////////////////////////////
	// Active mapping, loaded once after restart
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			load_q <= 1'b1;
		end else begin
			load_q <= 1'b0;
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			tx_map <= TX_DEF;
			rx_map <= RX_DEF;
			tx_len <= `CPRM_TX_DEF_LEN;
			rx_len <= `CPRM_RX_DEF_LEN;
			status_mapped <= 1'b1;
		end else if (load_q) begin
			tx_map <= nv_tx_q;
			rx_map <= nv_rx_q;
			tx_len <= list_len(nv_tx_q);
			rx_len <= list_len(nv_rx_q);
			status_mapped <= has_status(nv_tx_q, list_len(nv_tx_q));
		end
	end
endmodule

// *** verilog/cprm_device.sv ***
// Purpose: drive module end of the cyclic process data exchange
// Assumes: register file answers reg_rd_data in the cycle reg_rd_num is shown
// Notes: por_n is power-up, reset_n a restart that applies saved mapping
`timescale 1ns/1ps
`include "cprm_defines.svh"

// Function
// - one receive, one transmit object, five words
// - transmit goes out, receive comes in
// - mapping written through sub-indices sixteen onward
// - new mapping used only after save and restart
// - module register number is sub-index times 65536
// - configurer puts module registers after drive ones
// - zero slot ends the list
// - default transmit list 2,10,12,169,35
// - default receive list 2,3,5,7, empty
// - master reads small-series words as 16 bit; in_word_q keeps all 32 bits
// - master keeps the minimum cycle time
// - acyclic requests void the cycle time guarantee
// - module registers add no cycle time
// - status register always processed internally
// - exchange only after start of cycle
module cprm_device (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic por_n,
	cprm_link_if.dev link,
	output logic reg_wr_valid_q,
	output cprm_pkg::cprm_word_t reg_wr_num_q,
	output logic reg_wr_module_q,
	output logic [15:0] reg_wr_sub_q,
	output cprm_pkg::cprm_word_t reg_wr_data_q,
	output cprm_pkg::cprm_word_t reg_rd_num_q,
	output logic reg_rd_module_q,
	output logic [15:0] reg_rd_sub_q,
	input cprm_pkg::cprm_word_t reg_rd_data,
	output cprm_pkg::cprm_word_t status_word_q,
	output logic status_fresh_q,
	output logic busy_q
);
	import cprm_pkg::*;

	cprm_slots_t tx_map, rx_map;
	cprm_len_t tx_len, rx_len;
	logic status_mapped;
	cprm_dev_state_t state_q;
	cprm_len_t idx_q;
	cprm_word_t tx_num;
	cprm_word_t rx_num;
	logic tx_last;

	////////////////////////////////////////////////////////////////
	// Mapping store
	cprm_map_table u_map (
		.clk(clk),
		.reset_n(reset_n),
		.por_n(por_n),
		.cfg_valid(link.sdo_valid),
		.cfg_sub(link.sdo_sub),
		.cfg_data(link.sdo_data),
		.cfg_save(link.sdo_save),
		.tx_map(tx_map),
		.rx_map(rx_map),
		.tx_len(tx_len),
		.rx_len(rx_len),
		.status_mapped(status_mapped)
	);

	always_comb begin
		tx_num = '0;
		rx_num = '0;
		for (int i = 0; i < `CPRM_SLOTS; i++) begin
			if (idx_q == cprm_len_t'(i)) begin
				tx_num = tx_map[i];
				rx_num = rx_map[i];
			end
		end
	end

	assign tx_last = (tx_len == '0) || (idx_q == tx_len - 3'h1);

	////////////////////////////////////////////////////////////////
	// Cycle sequencer
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			state_q <= D_IDLE;
		end else begin
			unique case (state_q)
				D_IDLE: begin
					if (link.soc) begin
						state_q <= D_RX;
					end
				end
				D_RX: begin
					if (link.preq_valid && link.preq_last) begin
						state_q <= D_TX_ADDR;
					end
				end
				D_TX_ADDR: begin
					state_q <= D_TX_DATA;
				end
				D_TX_DATA: begin
					if (!tx_last) begin
						state_q <= D_TX_ADDR;
					end else if (status_mapped) begin
						state_q <= D_IDLE;
					end else begin
						state_q <= D_STAT_ADDR;
					end
				end
				D_STAT_ADDR: begin
					state_q <= D_STAT_DATA;
				end
				D_STAT_DATA: begin
					state_q <= D_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			idx_q <= '0;
		end else if (state_q == D_IDLE) begin
			idx_q <= '0;
		end else if (state_q == D_RX && link.preq_valid) begin
			idx_q <= link.preq_last ? '0 : ((idx_q == 3'h7) ? idx_q : idx_q + 3'h1);
		end else if (state_q == D_TX_DATA) begin
			idx_q <= idx_q + 3'h1;
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			busy_q <= 1'b0;
		end else begin
			busy_q <= (state_q != D_IDLE) || link.soc;
		end
	end

	////////////////////////////////////////////////////////////////
	// Receive object: words to drive or module registers
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			reg_wr_valid_q <= 1'b0;
			reg_wr_num_q <= '0;
			reg_wr_module_q <= 1'b0;
			reg_wr_sub_q <= '0;
			reg_wr_data_q <= '0;
		end else begin
			reg_wr_valid_q <= 1'b0;
			if (state_q == D_RX && link.preq_valid && idx_q < rx_len) begin
				reg_wr_valid_q <= 1'b1;
				reg_wr_num_q <= rx_num;
				reg_wr_module_q <= rx_num[`CPRM_WORD_W-1:`CPRM_MODULE_SHIFT] != '0;
				reg_wr_sub_q <= rx_num[`CPRM_WORD_W-1:`CPRM_MODULE_SHIFT];
				reg_wr_data_q <= link.preq_data;
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// Register read address for transmit and status
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			reg_rd_num_q <= '0;
			reg_rd_module_q <= 1'b0;
			reg_rd_sub_q <= '0;
		end else if (state_q == D_RX && link.preq_valid && link.preq_last) begin
			reg_rd_num_q <= tx_map[0];
			reg_rd_module_q <= tx_map[0][`CPRM_WORD_W-1:`CPRM_MODULE_SHIFT] != '0;
			reg_rd_sub_q <= tx_map[0][`CPRM_WORD_W-1:`CPRM_MODULE_SHIFT];
		end else if (state_q == D_TX_ADDR) begin
			// Module entries cost one read like any other
			reg_rd_num_q <= tx_num;
			reg_rd_module_q <= tx_num[`CPRM_WORD_W-1:`CPRM_MODULE_SHIFT] != '0;
			reg_rd_sub_q <= tx_num[`CPRM_WORD_W-1:`CPRM_MODULE_SHIFT];
		end else if (state_q == D_STAT_ADDR) begin
			reg_rd_num_q <= `CPRM_STATUS_REG;
			reg_rd_module_q <= 1'b0;
			reg_rd_sub_q <= '0;
		end
	end

	////////////////////////////////////////////////////////////////
	// Transmit object: poll response words
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			link.pres_valid <= 1'b0;
			link.pres_data <= '0;
			link.pres_last <= 1'b0;
		end else begin
			link.pres_valid <= 1'b0;
			link.pres_last <= 1'b0;
			if (state_q == D_TX_DATA) begin
				link.pres_valid <= 1'b1;
				link.pres_data <= (tx_len == '0) ? '0 : reg_rd_data;
				link.pres_last <= tx_last;
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// Status word, captured every cycle
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			status_word_q <= '0;
			status_fresh_q <= 1'b0;
		end else begin
			status_fresh_q <= 1'b0;
			if (state_q == D_STAT_DATA ||
				(state_q == D_TX_DATA && reg_rd_num_q == `CPRM_STATUS_REG &&
				tx_len != '0)) begin
				status_word_q <= reg_rd_data;
				status_fresh_q <= 1'b1;
			end
		end
	end
endmodule

// *** verilog/cprm_master.sv ***
// Purpose: managing node end of the cyclic exchange
// Assumes: user holds out_word stable while busy
// Notes: start requests inside the minimum cycle time are refused
`timescale 1ns/1ps
`include "cprm_defines.svh"
module cprm_master #(
	parameter int BASE_CYC = (`CPRM_BASE_NS + `CPRM_CLK_NS - 1) / `CPRM_CLK_NS,
	parameter int STEP_CYC = (`CPRM_STEP_NS + `CPRM_CLK_NS - 1) / `CPRM_CLK_NS,
	parameter int STAT_CYC = (`CPRM_STAT_NS + `CPRM_CLK_NS - 1) / `CPRM_CLK_NS
) (
	input wire logic clk,
	input wire logic reset_n,
	cprm_link_if.mst link,
	input wire logic cycle_start,
	input cprm_pkg::cprm_slots_t out_word,
	input cprm_pkg::cprm_len_t out_count,
	input cprm_pkg::cprm_len_t mapped_pairs,
	input wire logic status_mapped,
	input wire logic sdo_req,
	input cprm_pkg::cprm_sub_t sdo_sub,
	input cprm_pkg::cprm_word_t sdo_data,
	input wire logic sdo_save,
	output cprm_pkg::cprm_slots_t in_word_q,
	output cprm_pkg::cprm_len_t in_count_q,
	output logic cycle_done_q,
	output logic busy_q,
	output logic timing_ok_q
);
	import cprm_pkg::*;

	cprm_mst_state_t state_q;
	cprm_len_t idx_q;
	logic [31:0] timer_q;
	logic start;
	logic [31:0] min_cyc;

	assign start = cycle_start && state_q == M_IDLE && timer_q == '0;
	assign min_cyc = 32'(BASE_CYC) + 32'(STEP_CYC) * 32'((mapped_pairs == '0) ? 3'h0 :
		mapped_pairs - 3'h1) + (status_mapped ? 32'h0 : 32'(STAT_CYC));

	////////////////////////////////////////////////////////////////
	// Cycle spacing
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			timer_q <= '0;
		end else if (start) begin
			timer_q <= min_cyc - 32'h1;
		end else if (timer_q != '0) begin
			timer_q <= timer_q - 32'h1;
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			timing_ok_q <= 1'b1;
		end else if (sdo_req || sdo_save) begin
			timing_ok_q <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////
	// Sequence: start of cycle, poll request, poll response
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			state_q <= M_IDLE;
			idx_q <= '0;
			busy_q <= 1'b0;
		end else begin
			unique case (state_q)
				M_IDLE: begin
					idx_q <= '0;
					if (start) begin
						state_q <= M_REQ;
						busy_q <= 1'b1;
					end
				end
				M_REQ: begin
					idx_q <= idx_q + 3'h1;
					if (idx_q + 3'h1 >= out_count) begin
						state_q <= M_RESP;
						idx_q <= '0;
					end
				end
				M_RESP: begin
					if (link.pres_valid) begin
						idx_q <= idx_q + 3'h1;
						if (link.pres_last) begin
							state_q <= M_IDLE;
							busy_q <= 1'b0;
						end
					end
				end
			endcase
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			link.soc <= 1'b0;
			link.preq_valid <= 1'b0;
			link.preq_data <= '0;
			link.preq_last <= 1'b0;
		end else begin
			link.soc <= start;
			link.preq_valid <= state_q == M_REQ;
			link.preq_data <= (out_count == '0) ? '0 : out_word[idx_q];
			link.preq_last <= state_q == M_REQ && idx_q + 3'h1 >= out_count;
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			link.sdo_valid <= 1'b0;
			link.sdo_sub <= '0;
			link.sdo_data <= '0;
			link.sdo_save <= 1'b0;
		end else begin
			link.sdo_valid <= sdo_req;
			link.sdo_sub <= sdo_sub;
			link.sdo_data <= sdo_data;
			link.sdo_save <= sdo_save;
		end
	end

	////////////////////////////////////////////////////////////////
	// Collect response words; sign handling left to the user
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			in_word_q <= '0;
			in_count_q <= '0;
			cycle_done_q <= 1'b0;
		end else begin
			cycle_done_q <= 1'b0;
			if (state_q == M_RESP && link.pres_valid) begin
				if (idx_q < 3'(`CPRM_SLOTS)) begin
					in_word_q[idx_q] <= link.pres_data;
				end
				if (link.pres_last) begin
					in_count_q <= idx_q + 3'h1;
					cycle_done_q <= 1'b1;
				end
			end
		end
	end
endmodule

// *** dv/cprm_link_props.sv ***
// Purpose: link checks between managing node and drive module
// Assumes: one clock, reset_n active low
// Notes: instantiated beside the link in tb_top
`timescale 1ns/1ps
module cprm_link_props (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic soc,
	input wire logic preq_valid,
	input wire logic preq_last,
	input wire logic pres_valid,
	input wire logic pres_last
);
	import cprm_pkg::*;
	logic [2:0] pres_cnt_q;
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!reset_n);
////////////////////////////////////////////////////////////////////////////////
	// Transmit words since start of cycle
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			pres_cnt_q <= 3'h0;
		end else if (soc) begin
			pres_cnt_q <= 3'h0;
		end else if (pres_valid) begin
			pres_cnt_q <= pres_cnt_q + 3'h1;
		end
	end
////////////////////////////////////////////////////////////////////////////////
	a_soc_spacing: assert property (soc |=> !soc [*8])
		else $error("start of cycle repeated too soon");
	a_preq_after_soc: assert property ($rose(preq_valid) |-> $past(soc))
		else $error("receive word without start of cycle");
	a_pres_after_req: assert property (preq_last |-> ##3 pres_valid)
		else $error("transmit word not three cycles after last receive word");
	a_pres_word_gap: assert property (pres_valid && !pres_last |=> !pres_valid ##1 pres_valid)
		else $error("transmit words not every second cycle");
	a_pres_last_valid: assert property (pres_last |-> pres_valid)
		else $error("transmit last without valid");
	a_pres_list_end: assert property (pres_last |=> !pres_valid [*2])
		else $error("transmit word after last");
	a_pres_slot_count: assert property (pres_valid |-> pres_cnt_q < 3'h5)
		else $error("more than five transmit words");
	a_dir_no_overlap: assert property (pres_valid |-> !preq_valid)
		else $error("transmit and receive words overlap");
	a_preq_last_valid: assert property (preq_last |-> preq_valid)
		else $error("receive last without valid");
endmodule

// *** dv/tb_top.sv ***
// Purpose: both ends of the cyclic exchange joined by the link
// Assumes: small cycle time parameters 20/4/3
// Notes: register file modelled by rd_val
`timescale 1ns/1ps
module tb_top;
	import cprm_pkg::*;
	logic clk = 1'b0;
	logic reset_n = 1'b0;
	logic por_n = 1'b0;
	logic cycle_start = 1'b0;
	logic status_mapped = 1'b1;
	logic sdo_req = 1'b0;
	logic sdo_save = 1'b0;
	cprm_slots_t out_word = '0;
	cprm_slots_t in_word_q;
	cprm_len_t out_count = 3'h0;
	cprm_len_t mapped_pairs = 3'h4;
	cprm_len_t in_count_q;
	cprm_sub_t sdo_sub = 6'h00;
	cprm_word_t sdo_data = 32'h0;
	cprm_word_t rd_data, wr_num, wr_data, rd_num, stat_word;
	logic wr_v, wr_mod, rd_mod, stat_fresh, dbusy, mdone, mbusy, tok;
	logic [15:0] wr_sub, rd_sub;
	cprm_word_t seed = 32'h14cc4915;
	cprm_word_t exp_tx[5] = '{32'h2, 32'ha, 32'hc, 32'ha9, 32'h23};
	cprm_word_t exp_rx[5] = '{32'h2, 32'h3, 32'h5, 32'h7, 32'h0};
	logic [63:0] wq[$];
	int soc_n = 0;
	int fresh_n = 0;
	int bad_count = 0;
	int n_tests = 0;
	int k;
	cprm_link_if link();
	always #2 clk = ~clk;
////////////////////////////////////////////////////////////////////////////////
	function automatic cprm_word_t rd_val(input cprm_word_t n);
		return ~n ^ {n[15:0], n[31:16]};
	endfunction
	function automatic cprm_word_t lfsr(input cprm_word_t x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction
	assign rd_data = rd_val(rd_num);
	cprm_device i_cprm_device (.clk(clk), .reset_n(reset_n), .por_n(por_n), .link(link),
		.reg_wr_valid_q(wr_v), .reg_wr_num_q(wr_num), .reg_wr_module_q(wr_mod),
		.reg_wr_sub_q(wr_sub), .reg_wr_data_q(wr_data), .reg_rd_num_q(rd_num),
		.reg_rd_module_q(rd_mod), .reg_rd_sub_q(rd_sub), .reg_rd_data(rd_data),
		.status_word_q(stat_word), .status_fresh_q(stat_fresh), .busy_q(dbusy));
	cprm_master #(.BASE_CYC(20), .STEP_CYC(4), .STAT_CYC(3)) i_cprm_master (.clk(clk),
		.reset_n(reset_n), .link(link), .cycle_start(cycle_start), .out_word(out_word),
		.out_count(out_count), .mapped_pairs(mapped_pairs), .status_mapped(status_mapped),
		.sdo_req(sdo_req), .sdo_sub(sdo_sub), .sdo_data(sdo_data), .sdo_save(sdo_save),
		.in_word_q(in_word_q), .in_count_q(in_count_q), .cycle_done_q(mdone),
		.busy_q(mbusy), .timing_ok_q(tok));
	cprm_link_props i_cprm_link_props (.clk(clk), .reset_n(reset_n), .soc(link.soc),
		.preq_valid(link.preq_valid), .preq_last(link.preq_last),
		.pres_valid(link.pres_valid), .pres_last(link.pres_last));
////////////////////////////////////////////////////////////////////////////////
	task automatic chk(input string what, input cprm_word_t exp, input cprm_word_t got);
		n_tests++;
		if (got !== exp) begin
			bad_count++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic finish_test();
		$display("comparisons %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	task automatic run_cycle(input cprm_len_t n);
		repeat (45) @(posedge clk);
		wq.delete();
		for (int i = 0; i < 5; i++) begin
			seed = lfsr(seed);
			out_word[i] <= seed;
		end
		out_count <= n;
		cycle_start <= 1'b1;
		for (k = 0; k < 100 && mbusy !== 1'b1; k++) @(posedge clk);
		cycle_start <= 1'b0;
		for (k = 0; k < 200 && mdone !== 1'b1; k++) @(posedge clk);
		chk("cycle done", 32'h1, mdone);
	endtask
	task automatic chk_cycle(input int nw, input int nt);
		chk("write count", nw, wq.size());
		for (int i = 0; i < nw && i < wq.size(); i++) begin
			chk("write reg", exp_rx[i], wq[i][63:32]);
			chk("write data", out_word[i], wq[i][31:0]);
		end
		chk("in count", nt, in_count_q);
		for (int i = 0; i < nt; i++) begin
			chk("in word", rd_val(exp_tx[i]), in_word_q[i]);
		end
	endtask
	task automatic sdo(input cprm_sub_t s, input cprm_word_t d);
		sdo_sub <= s;
		sdo_data <= d;
		sdo_req <= 1'b1;
		@(posedge clk);
		sdo_req <= 1'b0;
		@(posedge clk);
	endtask
	task automatic restart();
		reset_n <= 1'b0;
		repeat (3) @(posedge clk);
		reset_n <= 1'b1;
		repeat (2) @(posedge clk);
	endtask
	task automatic map_new();
		sdo(6'h10, 32'h000f0000);
		sdo(6'h11, 32'h0);
		sdo(6'h16, 32'h2);
		sdo(6'h17, 32'h00070000);
		sdo(6'h18, 32'h0);
	endtask
////////////////////////////////////////////////////////////////////////////////
	// Receive writes and read addresses seen by the register file; soc and status fresh counts
	always @(posedge clk) begin
		if (link.soc === 1'b1) soc_n++;
		if (stat_fresh === 1'b1) fresh_n++;
		if (reset_n === 1'b1) begin
			chk("read module flag", rd_num[31:16] != 16'h0, rd_mod);
			chk("read module sub", rd_num[31:16], rd_sub);
		end
		if (wr_v === 1'b1) begin
			wq.push_back({wr_num, wr_data});
			chk("module flag", wr_num[31:16] != 16'h0, wr_mod);
			chk("module sub", wr_num[31:16], wr_sub);
		end
	end
	initial begin
		repeat (20000) @(posedge clk);
		bad_count++;
		finish_test();
	end
	initial begin
		repeat (20) @(posedge clk);
		reset_n <= 1'b1;
		por_n <= 1'b1;
		repeat (2) @(posedge clk);
		chk("timing ok", 32'h1, tok);
		run_cycle(3'h4);
		chk_cycle(4, 5);
		k = soc_n;
		cycle_start <= 1'b1;
		@(posedge clk);
		cycle_start <= 1'b0;
		repeat (8) @(posedge clk);
		chk("refused start", k, soc_n);
		map_new();
		chk("timing ok", 32'h0, tok);
		run_cycle(3'h4);
		chk_cycle(4, 5);
		restart();
		run_cycle(3'h4);
		chk_cycle(4, 5);
		map_new();
		sdo_save <= 1'b1;
		@(posedge clk);
		sdo_save <= 1'b0;
		run_cycle(3'h4);
		chk_cycle(4, 5);
		restart();
		status_mapped <= 1'b0;
		exp_tx[0] = 32'h000f0000;
		exp_rx[1] = 32'h00070000;
		run_cycle(3'h3);
		chk_cycle(2, 1);
		repeat (2) @(posedge clk);
		chk("status word", rd_val(32'h23), stat_word);
		chk("status fresh", 32'd5, fresh_n);
		chk("device busy", 32'h0, dbusy);
		finish_test();
	end
endmodule
